// ==== hw/lpm_sequencer.sv ====
// lpm_sequencer: power mode sequencer with regulator and pll control.
// assumes all inputs synchronous to clk; clk is the input clock itself.
`timescale 1ns/1ps
`default_nettype none
module lpm_sequencer
  import lpm_pkg::*;
#(
  parameter int RST_SEQ_CYCLES = LPM_RST_SEQ_CYCLES
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_b,
  // software requests
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic bypass_wr,
  input wire logic bypass_wdata,
  input wire logic mult_wr,
  input wire logic [LPM_MULT_W-1:0] mult_wdata,
  input wire logic regctl_wr,
  input wire lpm_regctl_s regctl_wdata,
  input wire logic cause_clr,
  // wake and event inputs
  input wire logic reset_pin_b,
  input wire logic sleep_wake_in,
  input wire logic rtc_async_irq,
  input wire logic rtc_wake_event,
  input wire logic eth_wake_req,
  input wire logic phy_wake_pin_b,
  input wire logic phy_pin_is_int,
  // regulator side
  input wire logic power_good_in_b,
  output logic regulator_wake_out,
  output logic core_power_on,
  // clock tree controls
  output lpm_clk_s clk_ctl,
  output logic [LPM_MULT_W-1:0] pll_mult,
  output logic buffered_osc_en,
  // system controls
  output logic hw_reset_b,
  output logic pad_oe_allow,
  output logic async_periph_block,
  output logic sdram_self_refresh_hold,
  // status
  output lpm_mode_e mode,
  output lpm_regctl_s regulator_control_reg,
  output logic [LPM_NUM_WAKE-1:0] wake_cause
);

  localparam int CNT_W = $clog2(RST_SEQ_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RST_SEQ_CYCLES - 1);

  lpm_mode_e mode_q, mode_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic bypass_q, bypass_d;
  logic [LPM_MULT_W-1:0] mult_pend_q, mult_pend_d;
  logic [LPM_MULT_W-1:0] mult_app_q, mult_app_d;
  lpm_regctl_s regctl_q, regctl_d;
  logic wake_out_q, wake_out_d;
  lpm_clk_s clk_ctl_q, clk_ctl_d;
  logic power_q, power_d;
  logic hw_rst_b_q, hw_rst_b_d;
  logic pad_oe_q, pad_oe_d;
  logic async_blk_q, async_blk_d;
  logic sdram_hold_q, sdram_hold_d;
  logic osc_en_q, osc_en_d;
  logic running;
  logic mult_ok;
  logic hib_armed;
  logic wake_hit;
  logic [LPM_NUM_WAKE-1:0] wake_src;
  logic [LPM_NUM_WAKE-1:0] wake_en;

  ////////////////////////////////////////////////////////////////////////
  // wake source qualification

  // phy pin counts only when it is not wired as the phy interrupt
  always_comb begin
    wake_src = '0;
    wake_src[LPM_WK_PHY] = ~phy_wake_pin_b & ~phy_pin_is_int;
    wake_src[LPM_WK_RTC] = rtc_wake_event;
    wake_src[LPM_WK_ETH] = eth_wake_req;
    wake_src[LPM_WK_RESET] = ~reset_pin_b;
  end

  // reset pin is always allowed; the others follow their enables
  always_comb begin
    wake_en = '0;
    wake_en[LPM_WK_PHY] = regctl_q.wake_en_phy;
    wake_en[LPM_WK_RTC] = regctl_q.wake_en_rtc;
    wake_en[LPM_WK_ETH] = regctl_q.wake_en_eth;
    wake_en[LPM_WK_RESET] = 1'b1;
  end

  // wake sources are looked at only while hibernating, never in the power wait
  assign hib_armed = (mode_q == LPM_HIBERNATE);

  lpm_wake_qual #(
    .N(LPM_NUM_WAKE)
  ) u_wake_qual (
    .clk(clk),
    .rst_b(rst_b),
    .armed(hib_armed),
    .cause_clr(cause_clr),
    .src(wake_src),
    .en(wake_en),
    .hit_q(wake_hit),
    .cause_q(wake_cause)
  );

  ////////////////////////////////////////////////////////////////////////
  // mode sequencing

  // software writes are honoured only while the core runs
  assign running = (mode_q == LPM_FULL_ON) || (mode_q == LPM_ACTIVE);
  assign mult_ok = (mult_wdata >= LPM_MULT_MIN) && (mult_wdata <= LPM_MULT_MAX);

  // next mode and the registers it owns
  always_comb begin
    mode_d = mode_q;
    cnt_d = cnt_q;
    bypass_d = bypass_q;
    mult_pend_d = mult_pend_q;
    mult_app_d = mult_app_q;
    regctl_d = regctl_q;
    wake_out_d = wake_out_q;
    if (running && bypass_wr) begin
      bypass_d = bypass_wdata;
    end
    if (running && mult_wr && mult_ok) begin
      mult_pend_d = mult_wdata;
    end
    if (running && regctl_wr) begin
      regctl_d = regctl_wdata;
    end
    case (mode_q)
      LPM_FULL_ON, LPM_ACTIVE: begin
        if (regctl_wr && regctl_wdata.regulator_level_field == LPM_LEVEL_OFF) begin
          mode_d = LPM_HIBERNATE;
          wake_out_d = 1'b0;
        end else if (deep_sleep_req) begin
          mode_d = LPM_DEEP_SLEEP;
        end else if (sleep_req) begin
          mode_d = LPM_SLEEP;
        end else if (bypass_d) begin
          mode_d = LPM_ACTIVE;
        end else begin
          mode_d = LPM_FULL_ON;
        end
      end
      LPM_SLEEP: begin
        // sleep wakes on any event and lands by the bypass choice
        if (sleep_wake_in) begin
          mode_d = bypass_q ? LPM_ACTIVE : LPM_FULL_ON;
        end
      end
      LPM_DEEP_SLEEP: begin
        // other interrupts are ignored here on purpose
        if (rtc_async_irq) begin
          mode_d = LPM_ACTIVE;
          bypass_d = 1'b1;
        end
      end
      LPM_HIBERNATE: begin
        // only a qualified wake leaves; the regulator is asked up at once
        if (wake_hit) begin
          mode_d = LPM_PWR_WAIT;
          wake_out_d = 1'b1;
        end
      end
      LPM_PWR_WAIT: begin
        // regulator startup time is unknown, so wait as long as it takes
        if (!power_good_in_b) begin
          mode_d = LPM_RST_SEQ;
          cnt_d = '0;
        end
      end
      LPM_RST_SEQ: begin
        // lost state returns to reset values; regctl is left alone
        bypass_d = 1'b0;
        mult_pend_d = LPM_MULT_RST;
        mult_app_d = LPM_MULT_RST;
        if (cnt_q == CNT_LAST) begin
          mode_d = LPM_FULL_ON;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        mode_d = LPM_FULL_ON;
      end
    endcase
    // the reset pin outside hibernation and the power wait restarts through the sequence
    if (!reset_pin_b && mode_q != LPM_HIBERNATE && mode_q != LPM_PWR_WAIT) begin
      mode_d = LPM_RST_SEQ;
      cnt_d = '0;
    end
    // a new multiplier only takes effect once full-on is reached
    if (mode_d == LPM_FULL_ON && mode_q != LPM_RST_SEQ) begin
      mult_app_d = mult_pend_d;
    end
  end

  // register the mode group; regctl survives any non power-on reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= LPM_FULL_ON;
      cnt_q <= '0;
      bypass_q <= 1'b0;
      mult_pend_q <= LPM_MULT_RST;
      mult_app_q <= LPM_MULT_RST;
      regctl_q <= LPM_REGCTL_RST;
      wake_out_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      bypass_q <= bypass_d;
      mult_pend_q <= mult_pend_d;
      mult_app_q <= mult_app_d;
      regctl_q <= regctl_d;
      wake_out_q <= wake_out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-mode outputs, decoded from the next mode so they align with it

  // clock, power and pad controls for each mode
  always_comb begin
    clk_ctl_d = '0;
    power_d = 1'b1;
    hw_rst_b_d = 1'b1;
    pad_oe_d = 1'b1;
    async_blk_d = 1'b0;
    sdram_hold_d = 1'b0;
    osc_en_d = 1'b1;
    case (mode_d)
      LPM_FULL_ON: begin
        clk_ctl_d = '{core_clk_en: 1'b1, sys_clk_en: 1'b1,
                      pll_en: 1'b1, pll_bypass: 1'b0};
      end
      LPM_ACTIVE: begin
        clk_ctl_d = '{core_clk_en: 1'b1, sys_clk_en: 1'b1,
                      pll_en: 1'b1, pll_bypass: 1'b1};
      end
      LPM_SLEEP: begin
        clk_ctl_d = '{core_clk_en: 1'b0, sys_clk_en: 1'b1,
                      pll_en: 1'b1, pll_bypass: bypass_q};
      end
      LPM_DEEP_SLEEP: begin
        clk_ctl_d = '0;
        async_blk_d = 1'b1;
      end
      LPM_HIBERNATE, LPM_PWR_WAIT: begin
        clk_ctl_d = '0;
        power_d = 1'b0;
        hw_rst_b_d = 1'b0;
        pad_oe_d = 1'b0;
        async_blk_d = 1'b1;
        osc_en_d = 1'b0;
        // the entering write lands on this same edge, so take the bit being
        // written; the old register copy would lag one hibernation behind
        sdram_hold_d = regctl_d.sdram_self_refresh_hold;
      end
      LPM_RST_SEQ: begin
        // clocks run with the pll at its default so reset logic is clocked
        clk_ctl_d = '{core_clk_en: 1'b1, sys_clk_en: 1'b1,
                      pll_en: 1'b1, pll_bypass: 1'b0};
        hw_rst_b_d = 1'b0;
        // the retained hold bit keeps sdram in self-refresh until full-on
        sdram_hold_d = regctl_d.sdram_self_refresh_hold;
      end
      default: begin
        clk_ctl_d = '0;
      end
    endcase
  end

  // register the output group; power-on looks like full-on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_ctl_q <= '{core_clk_en: 1'b1, sys_clk_en: 1'b1,
                     pll_en: 1'b1, pll_bypass: 1'b0};
      power_q <= 1'b1;
      hw_rst_b_q <= 1'b1;
      pad_oe_q <= 1'b1;
      async_blk_q <= 1'b0;
      sdram_hold_q <= 1'b0;
      osc_en_q <= 1'b1;
    end else begin
      clk_ctl_q <= clk_ctl_d;
      power_q <= power_d;
      hw_rst_b_q <= hw_rst_b_d;
      pad_oe_q <= pad_oe_d;
      async_blk_q <= async_blk_d;
      sdram_hold_q <= sdram_hold_d;
      osc_en_q <= osc_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flip-flop
  // no glue after the flops, so pads and the regulator never see decode glitches
  assign mode = mode_q;
  assign regulator_control_reg = regctl_q;
  assign regulator_wake_out = wake_out_q;
  assign core_power_on = power_q;
  assign clk_ctl = clk_ctl_q;
  assign pll_mult = mult_app_q;
  assign buffered_osc_en = osc_en_q;
  assign hw_reset_b = hw_rst_b_q;
  assign pad_oe_allow = pad_oe_q;
  assign async_periph_block = async_blk_q;
  assign sdram_self_refresh_hold = sdram_hold_q;

endmodule
`default_nettype wire

// ==== pkg/lpm_pkg.sv ====
// lpm_pkg: shared types and constants of the low power mode sequencer.
// assumes one clock domain; every control bit travels as a plain port.
package lpm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // power modes: five documented ones plus two wake-up sub-steps
  typedef enum logic [2:0] {
    LPM_FULL_ON    = 3'b000,
    LPM_ACTIVE     = 3'b001,
    LPM_SLEEP      = 3'b010,
    LPM_DEEP_SLEEP = 3'b011,
    LPM_HIBERNATE  = 3'b100,
    LPM_PWR_WAIT   = 3'b101,
    LPM_RST_SEQ    = 3'b110
  } lpm_mode_e;

  ////////////////////////////////////////////////////////////////////////
  // regulator control register, kept alive through hibernation
  typedef struct packed {
    logic       sdram_self_refresh_hold;
    logic       wake_en_eth;
    logic       wake_en_rtc;
    logic       wake_en_phy;
    logic [1:0] regulator_level_field;
  } lpm_regctl_s;

  localparam logic [1:0] LPM_LEVEL_OFF = 2'h0;
  localparam logic [1:0] LPM_LEVEL_RST = 2'h3;
  localparam lpm_regctl_s LPM_REGCTL_RST = '{
    sdram_self_refresh_hold: 1'b0,
    wake_en_eth: 1'b0,
    wake_en_rtc: 1'b0,
    wake_en_phy: 1'b0,
    regulator_level_field: LPM_LEVEL_RST
  };

  ////////////////////////////////////////////////////////////////////////
  // clock tree controls produced for each mode
  typedef struct packed {
    logic core_clk_en;
    logic sys_clk_en;
    logic pll_en;
    logic pll_bypass;
  } lpm_clk_s;

  ////////////////////////////////////////////////////////////////////////
  // pll multiplier range and reset value
  localparam int LPM_MULT_W = 7;
  localparam logic [6:0] LPM_MULT_MIN = 7'h05;
  localparam logic [6:0] LPM_MULT_MAX = 7'h40;
  localparam logic [6:0] LPM_MULT_RST = 7'h06;

  ////////////////////////////////////////////////////////////////////////
  // hibernate wake sources, one bit each
  localparam int LPM_NUM_WAKE = 4;
  localparam int LPM_WK_PHY = 0;
  localparam int LPM_WK_RTC = 1;
  localparam int LPM_WK_ETH = 2;
  localparam int LPM_WK_RESET = 3;

  // length of the hardware reset sequence, in clk cycles
  localparam int LPM_RST_SEQ_CYCLES = 16;

endpackage

// ==== hw/lpm_wake_qual.sv ====
// lpm_wake_qual: qualifies hibernate wake sources against their enables.
// assumes sources are synchronous to clk and active high.
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_qual
  import lpm_pkg::*;
#(
  parameter int N = LPM_NUM_WAKE
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic armed,
  input wire logic cause_clr,
  // sources and enables
  input wire logic [N-1:0] src,
  input wire logic [N-1:0] en,
  // results
  output logic hit_q,
  output logic [N-1:0] cause_q
);

  logic [N-1:0] hit_vec;
  logic [N-1:0] cause_d;
  logic hit_d;

  ////////////////////////////////////////////////////////////////////////
  // per source: act only while armed and enabled; set beats clear
  genvar gi;
  for (gi = 0; gi < N; gi++) begin : g_src
    assign hit_vec[gi] = armed & en[gi] & src[gi];
    assign cause_d[gi] = hit_vec[gi] | (cause_q[gi] & ~cause_clr);
  end

  assign hit_d = |hit_vec;

  // register the hit, high each cycle a source qualifies, and the sticky cause bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_q <= 1'b0;
      cause_q <= '0;
    end else begin
      hit_q <= hit_d;
      cause_q <= cause_d;
    end
  end

endmodule
`default_nettype wire

// ==== bench/lpm_sequencer_chk.sv ====
// lpm_sequencer_chk: port-level assertions on the power mode sequencer.
// assumes it is bound to lpm_sequencer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lpm_sequencer_chk
  import lpm_pkg::*;
#(
  parameter int RST_SEQ_CYCLES = LPM_RST_SEQ_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // watched inputs
  input wire logic reset_pin_b,
  input wire logic rtc_async_irq,
  input wire logic rtc_wake_event,
  input wire logic regctl_wr,
  input wire lpm_regctl_s regctl_wdata,
  input wire logic power_good_in_b,
  // watched outputs
  input wire logic regulator_wake_out,
  input wire logic core_power_on,
  input wire lpm_clk_s clk_ctl,
  input wire logic [LPM_MULT_W-1:0] pll_mult,
  input wire logic hw_reset_b,
  input wire logic pad_oe_allow,
  input wire logic async_periph_block,
  input wire lpm_mode_e mode,
  input wire lpm_regctl_s regulator_control_reg,
  input wire logic [LPM_NUM_WAKE-1:0] wake_cause
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] seq_cnt_q;
  logic [7:0] seq_cnt_d;

  ////////////////////////////////////////
  // cycles spent in the reset sequence; a reset pin restarts it
  always_comb begin
    seq_cnt_d = (mode == LPM_RST_SEQ && reset_pin_b) ? seq_cnt_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_cnt_q <= 8'h00;
    end else begin
      seq_cnt_q <= seq_cnt_d;
    end
  end

  ////////////////////////////////////////
  // wake pipeline is two flops deep, so allow up to three edges
  sequence s_wake_up;
    ##[1:3] (mode == LPM_PWR_WAIT && regulator_wake_out);
  endsequence

  a_deep_clk_off: assert property (mode == LPM_DEEP_SLEEP |-> !clk_ctl.core_clk_en && !clk_ctl.sys_clk_en)
    else $error("clocks run in deep sleep");
  a_deep_block: assert property (mode == LPM_DEEP_SLEEP |-> async_periph_block)
    else $error("async peripherals not blocked");
  a_deep_hold: assert property (mode == LPM_DEEP_SLEEP && !rtc_async_irq && reset_pin_b |=> mode == LPM_DEEP_SLEEP)
    else $error("deep sleep left without cause");
  a_rtc_active: assert property (mode == LPM_DEEP_SLEEP && rtc_async_irq && reset_pin_b |=> mode == LPM_ACTIVE && clk_ctl == 4'hf)
    else $error("rtc exit not to bypassed active");
  a_hib_off: assert property (mode == LPM_HIBERNATE |-> !core_power_on && clk_ctl == 4'h0 && !pad_oe_allow)
    else $error("hibernate keeps power, clocks or pads");
  a_level_off: assert property (regctl_wr && regctl_wdata.regulator_level_field == LPM_LEVEL_OFF && reset_pin_b && (mode == LPM_FULL_ON || mode == LPM_ACTIVE) |=> mode == LPM_HIBERNATE && !regulator_wake_out)
    else $error("level zero did not drop wake");
  a_wake_up: assert property (mode == LPM_HIBERNATE && rtc_wake_event && regulator_control_reg.wake_en_rtc |-> s_wake_up)
    else $error("enabled wake not signalled");
  a_wake_cause: assert property (mode == LPM_PWR_WAIT && $past(mode) == LPM_HIBERNATE |-> wake_cause != '0)
    else $error("wake without enabled cause");
  a_pg_hold: assert property (mode == LPM_PWR_WAIT && power_good_in_b |=> mode == LPM_PWR_WAIT)
    else $error("start before power good");
  a_rst_seq: assert property (mode == LPM_RST_SEQ |-> !hw_reset_b && seq_cnt_q < 8'(RST_SEQ_CYCLES))
    else $error("reset sequence wrong");
  a_full_on: assert property (mode == LPM_FULL_ON |-> clk_ctl == 4'he)
    else $error("full-on clock tree wrong");
  a_mult_rng: assert property (pll_mult >= LPM_MULT_MIN && pll_mult <= LPM_MULT_MAX)
    else $error("multiplier out of range");
endmodule

bind lpm_sequencer lpm_sequencer_chk #(.RST_SEQ_CYCLES(RST_SEQ_CYCLES)) lpm_sequencer_chk_inst (
  .clk, .rst_b, .reset_pin_b, .rtc_async_irq, .rtc_wake_event, .regctl_wr, .regctl_wdata,
  .power_good_in_b, .regulator_wake_out, .core_power_on, .clk_ctl, .pll_mult, .hw_reset_b,
  .pad_oe_allow, .async_periph_block, .mode, .regulator_control_reg, .wake_cause
);
`default_nettype wire

// ==== bench/lpm_reg_model.sv ====
// lpm_reg_model: external core regulator answering with power good.
// assumes regulator_wake_out is synchronous to clk; power is up at reset.
`timescale 1ns/1ps
`default_nettype none
module lpm_reg_model #(
  parameter int RAMP = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // regulator pins
  input wire logic regulator_wake_out,
  output logic power_good_in_b
);
  int ramp_q;

  ////////////////////////////////////////
  // high wake powers up after a ramp, low shuts down at once
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_q <= 0;
      power_good_in_b <= 1'b0;
    end else if (!regulator_wake_out) begin
      ramp_q <= RAMP;
      power_good_in_b <= 1'b1;
    end else begin
      ramp_q <= (ramp_q > 0) ? ramp_q - 1 : 0;
      power_good_in_b <= (ramp_q > 1);
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_low_power_mode_sequencer.sv ====
// test_low_power_mode_sequencer: self-checking bench of lpm_sequencer.
// assumes lpm_reg_model answers the regulator; 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_low_power_mode_sequencer import lpm_pkg::*;;
  logic clk, rst_b, sleep_req, deep_sleep_req, bypass_wr, bypass_wdata, mult_wr, regctl_wr;
  logic cause_clr, reset_pin_b, sleep_wake_in, rtc_async_irq, rtc_wake_event, eth_wake_req;
  logic phy_wake_pin_b, phy_pin_is_int, power_good_in_b, regulator_wake_out, core_power_on;
  logic buffered_osc_en, hw_reset_b, pad_oe_allow, async_periph_block, sdram_self_refresh_hold;
  logic hold;
  logic [6:0] mult_wdata, exp_m;
  logic [6:0] mults[5];
  logic [3:0] wake_cause;
  lpm_regctl_s regctl_wdata, regulator_control_reg;
  lpm_clk_s clk_ctl;
  logic [6:0] pll_mult;
  lpm_mode_e mode, last_mode;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int n_checks = 0;

  lpm_sequencer #(.RST_SEQ_CYCLES(2)) lpm_sequencer_inst (.clk, .rst_b, .sleep_req,
    .deep_sleep_req, .bypass_wr, .bypass_wdata, .mult_wr, .mult_wdata, .regctl_wr, .regctl_wdata,
    .cause_clr, .reset_pin_b, .sleep_wake_in, .rtc_async_irq, .rtc_wake_event, .eth_wake_req,
    .phy_wake_pin_b, .phy_pin_is_int, .power_good_in_b, .regulator_wake_out, .core_power_on,
    .clk_ctl, .pll_mult, .buffered_osc_en, .hw_reset_b, .pad_oe_allow, .async_periph_block,
    .sdram_self_refresh_hold, .mode, .regulator_control_reg, .wake_cause);
  lpm_reg_model lpm_reg_model_inst (.clk, .rst_b, .regulator_wake_out, .power_good_in_b);

  ////////////////////////////////////////
  // tasks: step, compare, bounded wait, verdict
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check_v(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_mode(input lpm_mode_e m);
    for (int i = 0; i < 100 && mode !== m; i++) tick();
    check_v("mode wait", m, mode);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // clock, watchdog and mode watcher (oldest note per mode change)
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #(20 * 20000);
    bad_count++;
    wrap_up();
  end
  always @(posedge clk) begin
    if (rst_b === 1'b1 && mode !== last_mode) begin
      if (exp_q.size() == 0) check_v("mode change", 8'hff, mode);
      else check_v("mode change", exp_q.pop_front(), mode);
    end
    last_mode = mode;
  end

  ////////////////////////////////////////
  // stimulus
  initial begin
    {sleep_req, deep_sleep_req, bypass_wr, bypass_wdata, mult_wr, regctl_wr, cause_clr} = '0;
    {mult_wdata, regctl_wdata, sleep_wake_in, rtc_async_irq, phy_pin_is_int} = '0;
    {reset_pin_b, eth_wake_req, rtc_wake_event, phy_wake_pin_b} = 4'b1001;
    rst_b = 1'b0;
    void'($urandom(32'h9d779481));
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    check_v("clk_ctl", 8'h0e, clk_ctl);
    check_v("pll_mult", 8'h06, pll_mult);
    check_v("wake_out", 8'h01, regulator_wake_out);
    check_v("osc_en", 8'h01, buffered_osc_en);
    check_v("regctl", 8'h03, regulator_control_reg);
    // multiplier limits, the reset value survives a rejected write
    mults = '{7'h04, 7'h05, 7'h40, 7'h41, 7'h05 + 7'($urandom_range(59))};
    exp_m = 7'h06;
    foreach (mults[k]) begin
      mult_wr = 1'b1;
      mult_wdata = mults[k];
      if (mults[k] >= 7'h05 && mults[k] <= 7'h40) exp_m = mults[k];
      tick();
      mult_wr = 1'b0;
      tick(2);
      check_v("pll_mult", exp_m, pll_mult);
    end
    // deep sleep wins over sleep; besides the reset pin only rtc leaves it, to active
    exp_q = '{LPM_DEEP_SLEEP, LPM_ACTIVE, LPM_FULL_ON};
    deep_sleep_req = 1'b1;
    sleep_req = 1'b1;
    tick();
    {deep_sleep_req, sleep_req} = 2'b00;
    {sleep_wake_in, reset_pin_b, eth_wake_req, rtc_wake_event, phy_wake_pin_b} = 5'b11110;
    tick(4);
    {sleep_wake_in, reset_pin_b, eth_wake_req, rtc_wake_event, phy_wake_pin_b} = 5'b01001;
    check_v("deep clk", 8'h00, clk_ctl);
    check_v("async blk", 8'h01, async_periph_block);
    check_v("deep stay", LPM_DEEP_SLEEP, mode);
    rtc_async_irq = 1'b1;
    tick();
    rtc_async_irq = 1'b0;
    tick();
    check_v("active clk", 8'h0f, clk_ctl);
    bypass_wr = 1'b1;
    tick();
    bypass_wr = 1'b0;
    tick();
    check_v("pll_mult", exp_m, pll_mult);
    // reset pin in deep sleep ends in full-on
    exp_q = '{LPM_DEEP_SLEEP, LPM_RST_SEQ, LPM_FULL_ON};
    deep_sleep_req = 1'b1;
    tick();
    deep_sleep_req = 1'b0;
    reset_pin_b = 1'b0;
    tick();
    reset_pin_b = 1'b1;
    wait_mode(LPM_FULL_ON);
    // sleep stops only the core clock; the full-on note above is still queued
    exp_q.push_back(LPM_SLEEP);
    exp_q.push_back(LPM_FULL_ON);
    sleep_req = 1'b1;
    tick();
    sleep_req = 1'b0;
    check_v("sleep clk", 8'h06, clk_ctl);
    sleep_wake_in = 1'b1;
    tick();
    sleep_wake_in = 1'b0;
    tick();
    // hibernate with each wake source: phy, rtc, eth, reset pin
    for (int i = 0; i < 4; i++) begin
      hold = 1'($urandom());
      regctl_wdata = '{hold, i == 2, i == 1, i == 0, LPM_LEVEL_OFF};
      exp_q = '{LPM_HIBERNATE, LPM_PWR_WAIT, LPM_RST_SEQ, LPM_FULL_ON};
      regctl_wr = 1'b1;
      tick();
      regctl_wr = 1'b0;
      check_v("wake_out", 8'h00, regulator_wake_out);
      check_v("hib pins", 8'h00,
              {core_power_on, clk_ctl, hw_reset_b, pad_oe_allow, buffered_osc_en});
      check_v("sdram", hold, sdram_self_refresh_hold);
      // disabled sources, and the wake pin while it serves as phy interrupt
      phy_pin_is_int = (i == 0);
      {reset_pin_b, eth_wake_req, rtc_wake_event, phy_wake_pin_b} = {1'b1, i != 2, i != 1, 1'b0};
      tick(4);
      {reset_pin_b, eth_wake_req, rtc_wake_event, phy_wake_pin_b, phy_pin_is_int} = 5'b10010;
      tick();
      check_v("hib stay", LPM_HIBERNATE, mode);
      {reset_pin_b, eth_wake_req, rtc_wake_event, phy_wake_pin_b} = 4'b1001 ^ (4'b0001 << i);
      tick();
      {reset_pin_b, eth_wake_req, rtc_wake_event, phy_wake_pin_b} = 4'b1001;
      wait_mode(LPM_RST_SEQ);
      check_v("sdram seq", hold, sdram_self_refresh_hold);
      check_v("cause", 8'h01 << i, wake_cause);
      wait_mode(LPM_FULL_ON);
      check_v("regctl kept", regctl_wdata, regulator_control_reg);
      check_v("mult lost", 8'h06, pll_mult);
      check_v("wake_out", 8'h01, regulator_wake_out);
      cause_clr = 1'b1;
      tick();
      cause_clr = 1'b0;
      tick();
      check_v("cause clr", 8'h00, wake_cause);
    end
    // second reset in mid-run
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick();
    check_v("mode rst", LPM_FULL_ON, mode);
    check_v("notes left", 8'h00, 8'(exp_q.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
